/* File: hw/slfu_unit.sv */
`timescale 1ns/1ns
// Overview of operation
// - line-crossing detection uses a 64-byte cache line.
// - a load straddling a line boundary becomes two memory accesses.
// - line-crossing loads wait until the load is oldest (near retirement).
// - buffered stores drain to cache only after the store retires.
// - younger load gets data bypassed from an older pending store.
// - no bypass on failed conditions; load reads cache after store drains.
// - forwarding needs equal start byte addresses of load and store.
// - forwarding needs every load byte inside the single store's bytes.
// - forwarded load completes only once store data is in the buffer.
// - loads without a pending-store dependence never wait for store data.
// - loads are taken one at a time; a blocked load holds off every younger load.
// - load covering several smaller stores takes the non-forwarding path.
// - forwarded data comes from the store buffer, no cache access.
// - floating-point forwarding takes a longer latency than integer.
// - load dependent on store with missing data is delayed until available.
module slfu_unit
(
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_st_alloc,
	input wire logic [slfu_pkg::ADDR_W-1:0] i_st_addr,
	input wire logic [slfu_pkg::SIZE_W-1:0] i_st_size,
	input wire logic i_st_data_vld,
	input wire logic [slfu_pkg::SB_IDX_W-1:0] i_st_data_idx,
	input wire logic [slfu_pkg::DATA_W-1:0] i_st_data,
	input wire logic i_st_retire,
	input wire logic i_ld_req,
	input wire logic [slfu_pkg::ADDR_W-1:0] i_ld_addr,
	input wire logic [slfu_pkg::SIZE_W-1:0] i_ld_size,
	input wire logic i_ld_fp,
	input wire logic i_ld_oldest,
	input wire logic i_cache_ack,
	input wire logic [slfu_pkg::DATA_W-1:0] i_cache_rdata,
	output logic o_ld_busy,
	output logic o_ld_done,
	output logic o_ld_fwd,
	output logic [slfu_pkg::DATA_W-1:0] o_ld_data,
	output logic o_cache_rd,
	output logic o_cache_wr,
	output logic [slfu_pkg::ADDR_W-1:0] o_cache_addr,
	output logic [slfu_pkg::DATA_W-1:0] o_cache_wdata,
	output logic [slfu_pkg::SIZE_W-1:0] o_cache_size,
	output logic o_sb_full
);
	import slfu_pkg::*;
	////////////////////////////////////////////////////////////////////////////////
	logic [ADDR_W-1:0] sb_addr_r [SB_DEPTH];
	logic [SIZE_W-1:0] sb_size_r [SB_DEPTH];
	logic [DATA_W-1:0] sb_data_r [SB_DEPTH];
	logic [SB_DEPTH-1:0] sb_vld_r, sb_dvld_r, sb_ret_r;
	logic [SB_IDX_W-1:0] head_r, tail_r, ret_ptr_r;
	logic [SB_IDX_W:0] cnt_r;
	logic drain_busy_r, ld_fp_r, ld_split_r, any_overlap;
	wire logic sb_full = (cnt_r == (SB_IDX_W+1)'(SB_DEPTH));
	wire logic do_alloc = i_st_alloc && !sb_full;
	wire logic can_drain = sb_vld_r[head_r] && sb_ret_r[head_r] && sb_dvld_r[head_r];
	wire logic drain_done = drain_busy_r && i_cache_ack;
	wire logic ld_ack = i_cache_ack && o_cache_rd;
	////////////////////////////////////////////////////////////////////////////////
	slfu_state_t state_r, state_nxt;
	logic [ADDR_W-1:0] ld_addr_r;
	logic [SIZE_W-1:0] ld_size_r;
	logic [SB_IDX_W-1:0] hit_idx_r, young_idx;
	logic [2:0] lat_r;
	logic [DATA_W-1:0] lo_data_r;
	logic [SB_DEPTH-1:0] overlap, fwd_ok;
	// walk from oldest to youngest so the youngest overlap wins
	always_comb
	begin
		any_overlap = 1'b0;
		young_idx = '0;
		overlap = '0;
		fwd_ok = '0;
		for (int k = 0; k < SB_DEPTH; k++)
		begin
			logic [SB_IDX_W-1:0] e;
			e = SB_IDX_W'(head_r + SB_IDX_W'(k));
			overlap[e] = sb_vld_r[e] && (ld_addr_r < sb_addr_r[e] + ADDR_W'(sb_size_r[e]))
				&& (sb_addr_r[e] < ld_addr_r + ADDR_W'(ld_size_r));
			fwd_ok[e] = (ld_addr_r == sb_addr_r[e]) && (ld_size_r <= sb_size_r[e]);
			if (overlap[e])
			begin
				any_overlap = 1'b1;
				young_idx = e;
			end
		end
	end
	// only the single youngest overlapping store may forward
	wire logic can_fwd = any_overlap && fwd_ok[young_idx];
	// line offset of the last byte
	wire logic [LINE_OFS_W:0] end_ofs = (LINE_OFS_W+1)'(i_ld_addr[LINE_OFS_W-1:0])
		+ (LINE_OFS_W+1)'(i_ld_size) - (LINE_OFS_W+1)'(1);
	wire logic req_split = end_ofs[LINE_OFS_W];
	wire logic [ADDR_W-1:0] line2_addr = {ld_addr_r[ADDR_W-1:LINE_OFS_W] + 1'b1, LINE_OFS_W'(0)};
	wire logic [SIZE_W-1:0] first_size = SIZE_W'(LINE_BYTES - int'(ld_addr_r[LINE_OFS_W-1:0]));
	wire logic [SIZE_W-1:0] second_size = SIZE_W'(ld_size_r - first_size);
	wire logic [DATA_W-1:0] merged = lo_data_r | (i_cache_rdata << (8 * int'(first_size)));
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			SLFU_IDLE:
				if (i_ld_req)
					state_nxt = SLFU_FWD;
			SLFU_FWD:
				if (!any_overlap)
					state_nxt = SLFU_CACHE;
				else if (can_fwd)
					state_nxt = SLFU_WAIT_DATA;
				else
					state_nxt = SLFU_WAIT_DRAIN;
			SLFU_WAIT_DATA:
				if (sb_dvld_r[hit_idx_r] && lat_r == 3'h0)
					state_nxt = SLFU_IDLE;
			SLFU_WAIT_DRAIN:
				// replay once conflicting stores are written
				if (!any_overlap)
					state_nxt = SLFU_CACHE;
			SLFU_CACHE:
				if (ld_ack)
					state_nxt = (ld_split_r) ? SLFU_SPLIT2 : SLFU_IDLE;
			SLFU_SPLIT2:
				if (ld_ack)
					state_nxt = SLFU_IDLE;
			default:
				state_nxt = SLFU_IDLE;
		endcase
	end
	// split access only issues when load is oldest
	wire logic cache_go = (state_r == SLFU_CACHE || state_r == SLFU_SPLIT2)
		&& !drain_busy_r && (!ld_split_r || i_ld_oldest) && !o_cache_rd;
	wire logic drain_go = can_drain && !drain_busy_r && !o_cache_rd && !cache_go;
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			state_r <= SLFU_IDLE;
			ld_addr_r <= '0;
			ld_size_r <= '0;
			ld_fp_r <= 1'b0;
			ld_split_r <= 1'b0;
			hit_idx_r <= '0;
			lat_r <= 3'h0;
			lo_data_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			if (state_r == SLFU_IDLE && i_ld_req)
			begin
				ld_addr_r <= i_ld_addr;
				ld_size_r <= i_ld_size;
				ld_fp_r <= i_ld_fp;
				ld_split_r <= req_split;
			end
			if (state_r == SLFU_FWD)
			begin
				hit_idx_r <= young_idx;
				lat_r <= (ld_fp_r ? FP_FWD_CNT : INT_FWD_CNT) - 3'h1;
			end
			else if (state_r == SLFU_WAIT_DATA && lat_r != 3'h0)
				lat_r <= lat_r - 3'h1;
			// only the bytes of the first line belong to the load
			if (state_r == SLFU_CACHE && ld_ack)
				lo_data_r <= i_cache_rdata & ~({DATA_W{1'b1}} << (8 * int'(first_size)));
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// store buffer update
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			sb_vld_r <= '0;
			sb_dvld_r <= '0;
			sb_ret_r <= '0;
			head_r <= '0;
			tail_r <= '0;
			cnt_r <= '0;
			ret_ptr_r <= '0;
			drain_busy_r <= 1'b0;
		end
		else
		begin
			if (do_alloc)
			begin
				sb_vld_r[tail_r] <= 1'b1;
				sb_dvld_r[tail_r] <= 1'b0;
				sb_ret_r[tail_r] <= 1'b0;
				sb_addr_r[tail_r] <= i_st_addr;
				sb_size_r[tail_r] <= i_st_size;
				tail_r <= tail_r + 1'b1;
			end
			if (i_st_data_vld)
			begin
				sb_data_r[i_st_data_idx] <= i_st_data;
				sb_dvld_r[i_st_data_idx] <= 1'b1;
			end
			if (i_st_retire && sb_vld_r[ret_ptr_r] && !sb_ret_r[ret_ptr_r])
			begin
				sb_ret_r[ret_ptr_r] <= 1'b1;
				ret_ptr_r <= ret_ptr_r + 1'b1;
			end
			if (drain_go)
				drain_busy_r <= 1'b1;
			if (drain_done)
			begin
				drain_busy_r <= 1'b0;
				sb_vld_r[head_r] <= 1'b0;
				head_r <= head_r + 1'b1;
			end
			cnt_r <= cnt_r + (SB_IDX_W+1)'(do_alloc) - (SB_IDX_W+1)'(drain_done);
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// outputs
	wire logic fwd_fin = state_r == SLFU_WAIT_DATA && sb_dvld_r[hit_idx_r] && lat_r == 3'h0;
	wire logic ld_fin = ld_ack && (state_r == SLFU_SPLIT2 || !ld_split_r);
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			o_ld_done <= 1'b0;
			o_ld_fwd <= 1'b0;
			o_ld_data <= '0;
			o_cache_rd <= 1'b0;
			o_cache_wr <= 1'b0;
			o_cache_addr <= '0;
			o_cache_wdata <= '0;
			o_cache_size <= '0;
			o_ld_busy <= 1'b0;
			o_sb_full <= 1'b0;
		end
		else
		begin
			o_ld_busy <= state_nxt != SLFU_IDLE;
			o_sb_full <= sb_full;
			o_ld_done <= fwd_fin || ld_fin;
			o_ld_fwd <= fwd_fin;
			if (fwd_fin)
				o_ld_data <= sb_data_r[hit_idx_r];
			else if (ld_fin)
				o_ld_data <= ld_split_r ? merged : i_cache_rdata;
			o_cache_rd <= cache_go || (o_cache_rd && !i_cache_ack);
			o_cache_wr <= drain_go || (o_cache_wr && !i_cache_ack);
			if (cache_go)
			begin
				o_cache_addr <= (state_r == SLFU_SPLIT2) ? line2_addr : ld_addr_r;
				o_cache_size <= !ld_split_r ? ld_size_r
					: (state_r == SLFU_SPLIT2) ? second_size : first_size;
			end
			else if (drain_go)
			begin
				o_cache_addr <= sb_addr_r[head_r];
				o_cache_size <= sb_size_r[head_r];
				o_cache_wdata <= sb_data_r[head_r];
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// assertions
	a_no_early_drain: assert property (@(posedge i_clk) disable iff (!i_resetn)
		drain_go |-> sb_ret_r[head_r]) else $error("store drained before retire");
	a_fwd_same_start: assert property (@(posedge i_clk) disable iff (!i_resetn)
		fwd_fin |-> ld_addr_r == sb_addr_r[hit_idx_r]) else $error("forward start mismatch");
	a_fwd_contained: assert property (@(posedge i_clk) disable iff (!i_resetn)
		fwd_fin |-> ld_size_r <= sb_size_r[hit_idx_r]) else $error("forward not contained");
	a_fwd_data_rdy: assert property (@(posedge i_clk) disable iff (!i_resetn)
		fwd_fin |-> sb_dvld_r[hit_idx_r]) else $error("forward before data");
	a_fwd_no_cache: assert property (@(posedge i_clk) disable iff (!i_resetn)
		fwd_fin |=> o_ld_fwd && o_ld_data == $past(sb_data_r[hit_idx_r]))
		else $error("forward data wrong");
	a_blocked_waits: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(state_r == SLFU_FWD && any_overlap && !can_fwd) |=> state_r == SLFU_WAIT_DRAIN)
		else $error("blocked load not held");
	a_indep_no_wait: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(state_r == SLFU_FWD && !any_overlap) |=> state_r == SLFU_CACHE)
		else $error("independent load waited");
	a_split_oldest: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(cache_go && ld_split_r) |-> i_ld_oldest) else $error("split issued early");
	a_fp_latency: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(state_r == SLFU_FWD && can_fwd && ld_fp_r) |=> lat_r == FP_FWD_CNT - 3'h1)
		else $error("fp forward latency");
	c_fwd: cover property (@(posedge i_clk) fwd_fin);
	c_split: cover property (@(posedge i_clk) state_r == SLFU_SPLIT2 && i_cache_ack);
	c_replay: cover property (@(posedge i_clk) state_r == SLFU_WAIT_DRAIN ##1 state_r == SLFU_CACHE);
endmodule : slfu_unit

/* File: hw/slfu_pkg.sv */
package slfu_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 64;
	localparam int BYTES = 8;
	localparam int SIZE_W = 4;
	localparam int LINE_BYTES = 64;
	localparam int LINE_OFS_W = 6;
	localparam int SB_DEPTH = 4;
	localparam int SB_IDX_W = 2;
	localparam int INT_FWD_LAT = 1;
	localparam int FP_FWD_LAT = 4;
	localparam logic [2:0] INT_FWD_CNT = 3'(INT_FWD_LAT);
	localparam logic [2:0] FP_FWD_CNT = 3'(FP_FWD_LAT);
	typedef enum logic [2:0]
	{
		SLFU_IDLE = 3'b000,
		SLFU_FWD = 3'b001,
		SLFU_WAIT_DATA = 3'b010,
		SLFU_WAIT_DRAIN = 3'b011,
		SLFU_CACHE = 3'b100,
		SLFU_SPLIT2 = 3'b101
	} slfu_state_t;
endpackage : slfu_pkg

/* File: verif/slfu_cache_model.sv */
`timescale 1ns/1ns
module slfu_cache_model
	import slfu_pkg::*;
#(
	parameter int LAT = 2
)
(
	input wire logic i_clk,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [slfu_pkg::ADDR_W-1:0] i_addr,
	input wire logic [slfu_pkg::SIZE_W-1:0] i_size,
	input wire logic [slfu_pkg::DATA_W-1:0] i_wdata,
	output logic o_ack,
	output logic [slfu_pkg::DATA_W-1:0] o_rdata
);
	logic [7:0] mem [256];
	initial
	begin
		o_ack = 1'b0;
		o_rdata = 64'h0;
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i * 7 + 3);
		forever
		begin
			@(posedge i_clk);
			if (i_rd || i_wr)
			begin
				repeat (LAT) @(posedge i_clk);
				#1;
				for (int i = 0; i < 8; i++)
				begin
					if (i_wr && i < i_size)
						mem[8'(i_addr + i)] = i_wdata[8*i+:8];
					o_rdata[8*i+:8] = mem[8'(i_addr + i)];
				end
				o_ack = 1'b1;
				@(posedge i_clk);
				#1;
				o_ack = 1'b0;
				// no stale data once the answer is gone
				o_rdata = ~o_rdata;
			end
		end
	end
endmodule : slfu_cache_model

/* File: verif/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
	import slfu_pkg::*;
	logic clk = 1'b0, resetn = 1'b0, s_al = 1'b0, s_v = 1'b0, s_r = 1'b0, l_q = 1'b0;
	logic l_fp = 1'b0, l_old = 1'b1, ack, busy, done, fwd, c_rd, c_wr, full, g_f, hit;
	logic [31:0] s_a = 32'h0, l_a = 32'h0, c_a;
	logic [3:0] s_s = 4'h0, l_s = 4'h0, c_s;
	logic [1:0] s_i = 2'h0, sidx = 2'h0;
	logic [63:0] s_d = 64'h0, c_rdata, c_wd, l_d, g_d;
	logic [31:0] rd_a [$];
	logic [3:0] rd_s [$];
	int err_count = 0, samples_checked = 0, cyc = 0, lat = 0, lat_i = 0, n = 0;
	always #5 clk = ~clk;
	slfu_unit uut (.i_clk(clk), .i_resetn(resetn), .i_st_alloc(s_al), .i_st_addr(s_a),
		.i_st_size(s_s), .i_st_data_vld(s_v), .i_st_data_idx(s_i), .i_st_data(s_d),
		.i_st_retire(s_r), .i_ld_req(l_q), .i_ld_addr(l_a), .i_ld_size(l_s), .i_ld_fp(l_fp),
		.i_ld_oldest(l_old), .i_cache_ack(ack), .i_cache_rdata(c_rdata), .o_ld_busy(busy),
		.o_ld_done(done), .o_ld_fwd(fwd), .o_ld_data(l_d), .o_cache_rd(c_rd), .o_cache_wr(c_wr),
		.o_cache_addr(c_a), .o_cache_wdata(c_wd), .o_cache_size(c_s), .o_sb_full(full));
	slfu_cache_model #(.LAT(2)) mdl (.i_clk(clk), .i_rd(c_rd), .i_wr(c_wr), .i_addr(c_a),
		.i_size(c_s), .i_wdata(c_wd), .o_ack(ack), .o_rdata(c_rdata));
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (c_rd && ack)
		begin
			rd_a.push_back(c_a);
			rd_s.push_back(c_s);
		end
		// a healthy run needs well under a thousand cycles
		if (cyc == 5000)
		begin
			err_count++;
			results();
		end
	end
	task tick;
		@(posedge clk);
		#1;
	endtask : tick
	task check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	function automatic logic [63:0] msk(input logic [3:0] s);
		return s[3] ? 64'hFFFFFFFFFFFFFFFF : (64'h1 << (8 * s)) - 64'h1;
	endfunction : msk
	function automatic logic [63:0] ib(input logic [31:0] a);
		logic [63:0] v;
		for (int i = 0; i < 8; i++)
			v[8*i+:8] = 8'((a + i) * 7 + 3);
		return v;
	endfunction : ib
	task sdata(input logic [1:0] i, input logic [63:0] d);
		s_v = 1'b1;
		s_i = i;
		s_d = d;
		tick;
		s_v = 1'b0;
		tick;
	endtask : sdata
	task st(input logic [31:0] a, input logic [3:0] s, input logic [63:0] d, input logic v);
		s_al = 1'b1;
		s_a = a;
		s_s = s;
		tick;
		s_al = 1'b0;
		tick;
		if (v)
			sdata(sidx, d);
		sidx = sidx + 2'h1;
	endtask : st
	task ret(input int k);
		repeat (k)
		begin
			s_r = 1'b1;
			tick;
			s_r = 1'b0;
			tick;
		end
	endtask : ret
	task go(input logic [31:0] a, input logic [3:0] s, input logic fp);
		l_q = 1'b1;
		l_a = a;
		l_s = s;
		l_fp = fp;
		lat = 0;
		hit = 1'b0;
		n = rd_a.size();
		tick;
		l_q = 1'b0;
	endtask : go
	task hold(input int k);
		repeat (k)
		begin
			hit = hit | done | c_wr | (rd_a.size() != n);
			tick;
		end
	endtask : hold
	task fin;
		while (!done && lat < 300)
		begin
			tick;
			lat++;
		end
		check(done, 1'b1);
		g_f = fwd;
		g_d = l_d & msk(l_s);
	endtask : fin
	////////////////////////////////////////////////////////////////////////////////
	task t_fwd;
		st(32'h10, 4'h4, 64'h44332211, 1'b1);
		go(32'h10, 4'h4, 1'b0);
		fin;
		lat_i = lat;
		check(g_f, 1'b1);
		check(g_d, 64'h44332211);
		check(rd_a.size() - n, 0);
		go(32'h10, 4'h4, 1'b1);
		fin;
		check(g_f, 1'b1);
		check(lat > lat_i, 1'b1);
		ret(1);
		repeat (15) tick;
	endtask : t_fwd
	task t_block;
		st(32'h18, 4'h4, 64'h88776655, 1'b1);
		go(32'h19, 4'h1, 1'b0);
		hold(20);
		check(hit, 1'b0);
		ret(1);
		fin;
		check(g_f, 1'b0);
		check(g_d, 64'h66);
		st(32'h20, 4'h4, 64'hA3A2A1A0, 1'b1);
		st(32'h24, 4'h4, 64'hB3B2B1B0, 1'b1);
		go(32'h20, 4'h8, 1'b0);
		hold(10);
		check(done, 1'b0);
		ret(2);
		fin;
		check(g_f, 1'b0);
		check(g_d, 64'hB3B2B1B0A3A2A1A0);
		st(32'h60, 4'h2, 64'hBBAA, 1'b1);
		go(32'h60, 4'h4, 1'b0);
		hold(10);
		check(hit, 1'b0);
		ret(1);
		fin;
		check(g_f, 1'b0);
		check(g_d, (ib(32'h60) & 64'hFFFF0000) | 64'hBBAA);
	endtask : t_block
	task t_avail;
		st(32'h40, 4'h4, 64'h0, 1'b0);
		go(32'h80, 4'h4, 1'b0);
		fin;
		check(g_d, ib(32'h80) & msk(4'h4));
		go(32'h40, 4'h4, 1'b0);
		hold(10);
		check(done, 1'b0);
		check(busy, 1'b1);
		sdata(sidx - 2'h1, 64'hD4D3D2D1);
		fin;
		check(g_f, 1'b1);
		check(g_d, 64'hD4D3D2D1);
		ret(1);
		repeat (15) tick;
	endtask : t_avail
	task t_split;
		l_old = 1'b0;
		go(32'hBC, 4'h8, 1'b0);
		hold(10);
		check(hit, 1'b0);
		l_old = 1'b1;
		fin;
		check(rd_a.size() - n, 2);
		check(rd_a[n], 32'hBC);
		check(rd_s[n], 4'h4);
		check(rd_a[n+1], 32'hC0);
		check(rd_s[n+1], 4'h4);
		check(g_d, ib(32'hBC));
	endtask : t_split
	task t_full;
		for (int i = 0; i < 4; i++)
			st(32'hE0 + 32'(8 * i), 4'h8, 64'hC0C1C2C3C4C5C6C0 + 64'(i), 1'b1);
		check(full, 1'b1);
		ret(4);
		repeat (60) tick;
		check(full, 1'b0);
		go(32'hF8, 4'h8, 1'b0);
		fin;
		check(g_f, 1'b0);
		check(g_d, 64'hC0C1C2C3C4C5C6C3);
	endtask : t_full
	task results;
		if (err_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results
	initial
	begin
		repeat (10) tick;
		resetn = 1'b1;
		tick;
		t_fwd;
		t_block;
		t_avail;
		t_split;
		t_full;
		results();
	end
endmodule : tb_top
